//--- shared/miu_pkg.sv
// Package for the microcontroller interrupt unit: register offsets, bit positions,
// reset values and state encodings shared by the unit and its edge detector.
// Assumes an 8-bit register space reached over classic Wishbone.
package miu_pkg;
   // Register byte addresses on the bus.
   localparam logic [7:0] IRQ_REQUEST_FLAGS_ADDR = 8'hc8;
   localparam logic [7:0] IRQ_ENABLE_MASK_ADDR = 8'hc9;
   localparam logic [7:0] PIN_EDGE_SELECT_ADDR = 8'hbf;
   localparam logic [7:0] STACK_POINTER_ADDR = 8'hdf;
   localparam logic [7:0] WORK_SAVE_ADDR = 8'he0;
   localparam logic [7:0] FLAG_SAVE_ADDR = 8'he1;
   // Source bit positions, shared by flags and enables; then the global enable and edge field positions.
   localparam int EXT_PIN_BIT = 0;
   localparam int CAPTURE_ONE_BIT = 1;
   localparam int CAPTURE_TWO_BIT = 2;
   localparam int GENERAL_TIMER_BIT = 4;
   localparam int TIMER_COUNTER_BIT = 5;
   localparam int USB_BIT = 6;
   localparam logic [7:0] SOURCE_USED_MASK = 8'h77;
   localparam int GLOBAL_ENABLE_BIT = 7;
   localparam int EDGE_FIELD_LSB = 3;
   // Program flag bits excluded from save and restore.
   localparam logic [7:0] PROTECTED_FLAG_MASK = 8'hc0;
   // Reset values.
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [2:0] STACK_LEVEL_RESET = 3'h7;
   localparam logic [1:0] EDGE_FIELD_RESET = 2'h2;
   // Edge select encodings.
   localparam logic [1:0] EDGE_RISING = 2'h1;
   localparam logic [1:0] EDGE_FALLING = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   // Shared interrupt vector.
   localparam logic [15:0] IRQ_VECTOR = 16'h0008;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_ENTER = 2'b01,
      ST_SERVICE = 2'b10
   } miu_state_t;
endpackage

//--- design/miu_edge_detect.sv
// Edge detector for the external pin interrupt with selectable polarity.
// Assumes the pin is already synchronous to clk.
`timescale 1ns/1ps
module miu_edge_detect
   import miu_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Pin and selection.
   input wire logic pinLevel,
   input wire logic [1:0] edgeSelect,
   // Detected trigger.
   output logic trigger
);
   typedef struct packed {
      logic prevLevel;
      logic trig;
   } miu_edge_t;
   miu_edge_t state_reg, state_next;

   // Compare against the previous level; the reserved code never triggers.
   always_comb begin
      state_next = state_reg;
      state_next.prevLevel = pinLevel;
      unique case (edgeSelect)
         EDGE_RISING: state_next.trig = pinLevel & ~state_reg.prevLevel;
         EDGE_FALLING: state_next.trig = ~pinLevel & state_reg.prevLevel;
         EDGE_BOTH: state_next.trig = pinLevel ^ state_reg.prevLevel;
         default: state_next.trig = 1'b0;
      endcase
   end

   // Track the live pin level through reset, so no false edge follows the release.
   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= '{prevLevel: pinLevel, trig: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign trigger = state_reg.trig;

   a_rise_detect: assert property (@(posedge clk) disable iff (srst)
      (edgeSelect == EDGE_RISING && $rose(pinLevel) && $past(edgeSelect) == EDGE_RISING)
      |=> trigger) else $error("rising edge missed");
   a_reserved_quiet: assert property (@(posedge clk) disable iff (srst)
      (edgeSelect == 2'h0) |=> !trigger) else $error("reserved edge code triggered");
endmodule

//--- design/miu_interrupt_unit.sv
// Interrupt unit of a small 8-bit controller: flags, enables, global enable,
// vector entry and return, and one-level save of work and program flag registers.
// Assumes the core sequencer pulses instrBoundary, retInstr, saveInstr and restoreInstr
// for one cycle, and that peripheral events are one-cycle pulses on clk.
//
// Summary of operation
// - Six sources: five internal, one pin.
// - Pin edge wakes chip from power-down.
// - Entry clears global enable.
// - Return sets global enable again.
// - Per-source enable permits or suppresses source.
// - Entry pushes stack, jumps to vector 8.
// - Return ends service, resumes program.
// - Enable register layout at 0C9H, reset zero.
// - Source request sets its flag.
// - Flag register at 0C8H, read/write, reset zero.
// - Global enable is stack register bit 7.
// - No service without global enable.
// - Save and restore work and flag registers.
// - Save and restore skip timeout, power-down bits.
// - Flag sets regardless of source enable.
// - Wake edge latches pin flag, vector follows.
// - Two-bit pin edge select field.
`timescale 1ns/1ps
module miu_interrupt_unit
   import miu_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Classic Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [7:0] wb_dat_i,
   input wire logic wb_sel_i,
   output logic [7:0] wb_dat_o,
   output logic wb_ack_o,
   // Peripheral request pulses.
   input wire logic generalTimerEvent,
   input wire logic timerCounterEvent,
   input wire logic usbEvent,
   input wire logic captureOneEvent,
   input wire logic captureTwoEvent,
   // External pin and power state.
   input wire logic externalPinInterrupt,
   input wire logic powerDown,
   output logic wakeRequest,
   // Core sequencer.
   input wire logic instrBoundary,
   input wire logic retInstr,
   input wire logic saveInstr,
   input wire logic restoreInstr,
   input wire logic [7:0] workRegIn,
   input wire logic [7:0] progFlagIn,
   output logic takeVector,
   output logic [15:0] vectorAddr,
   output logic [7:0] workRegOut,
   output logic [7:0] progFlagOut,
   output logic restoreValid,
   output logic inService
);
   // Everything the unit remembers outside its edge detector sits in one struct, registered on every edge.
   // The stack level counts down from its reset value, so a push subtracts one
   // and a return adds one; software may also rewrite it through the bus.
   typedef struct packed {
      miu_state_t st;
      logic [7:0] flags;
      logic [7:0] enables;
      logic globalEnable;
      logic [2:0] stackLevel;
      logic [1:0] edgeField;
      logic [7:0] workSave;
      logic [7:0] flagSave;
      logic [7:0] rdData;
      logic ack;
      logic take;
      logic wake;
      logic [7:0] workOut;
      logic [7:0] flagOut;
      logic restoreV;
      logic busy;
   } miu_regs_t;
   miu_regs_t state_reg, state_next;

   logic pinTrigger;
   logic [7:0] sourceEvents;
   logic busWrite;
   logic busRead;
   logic pendingIrq;

   miu_edge_detect edgeDetect (
      .clk(clk),
      .srst(srst),
      .pinLevel(externalPinInterrupt),
      .edgeSelect(state_reg.edgeField),
      .trigger(pinTrigger)
   );

   // Gather the six sources into the flag layout; unused bits stay zero.
   always_comb begin
      sourceEvents = 8'h00;
      sourceEvents[EXT_PIN_BIT] = pinTrigger;
      sourceEvents[CAPTURE_ONE_BIT] = captureOneEvent;
      sourceEvents[CAPTURE_TWO_BIT] = captureTwoEvent;
      sourceEvents[GENERAL_TIMER_BIT] = generalTimerEvent;
      sourceEvents[TIMER_COUNTER_BIT] = timerCounterEvent;
      sourceEvents[USB_BIT] = usbEvent;
   end

   // A write takes effect on the edge that raises ack, so it lands exactly once.
   assign busWrite = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i & ~state_reg.ack;
   assign busRead = wb_cyc_i & wb_stb_i & ~wb_we_i & ~state_reg.ack;
   // A source is pending only with its flag and its enable; the global enable and
   // the instruction boundary are applied in the sequencer below.
   assign pendingIrq = |(state_reg.flags & state_reg.enables);

   // Next-state logic for the whole unit.
   always_comb begin
      state_next = state_reg;
      state_next.take = 1'b0;
      state_next.restoreV = 1'b0;
      state_next.ack = wb_cyc_i & wb_stb_i & ~state_reg.ack;
      // Bus writes first, so a same-cycle hardware event below overrides them.
      if (busWrite) begin
         unique case (wb_adr_i)
            IRQ_REQUEST_FLAGS_ADDR: state_next.flags = wb_dat_i & SOURCE_USED_MASK;
            IRQ_ENABLE_MASK_ADDR: state_next.enables = wb_dat_i & SOURCE_USED_MASK;
            PIN_EDGE_SELECT_ADDR: state_next.edgeField = wb_dat_i[EDGE_FIELD_LSB +: 2];
            STACK_POINTER_ADDR: begin
               state_next.globalEnable = wb_dat_i[GLOBAL_ENABLE_BIT];
               state_next.stackLevel = wb_dat_i[2:0];
            end
            // The saved context reads back only; writes to it fall here.
            default: ;
         endcase
      end
      // Hardware sets win over a clearing write; flags never clear themselves.
      state_next.flags = state_next.flags | sourceEvents;
      // Read mux; unmapped addresses read zero and are still acknowledged.
      if (busRead) begin
         unique case (wb_adr_i)
            IRQ_REQUEST_FLAGS_ADDR: state_next.rdData = state_reg.flags;
            IRQ_ENABLE_MASK_ADDR: state_next.rdData = state_reg.enables;
            PIN_EDGE_SELECT_ADDR: state_next.rdData = {3'h0, state_reg.edgeField, 3'h0};
            STACK_POINTER_ADDR: state_next.rdData = {state_reg.globalEnable, 4'h0,
                                                     state_reg.stackLevel};
            WORK_SAVE_ADDR: state_next.rdData = state_reg.workSave;
            FLAG_SAVE_ADDR: state_next.rdData = state_reg.flagSave;
            default: state_next.rdData = 8'h00;
         endcase
      end
      // The pin wakes the chip from power-down; its flag is latched above.
      // The pulse goes to the clock controller, which owns the restart timing.
      state_next.wake = powerDown & pinTrigger;
      // One-level context buffer; timeout and power-down bits are left alone.
      if (saveInstr) begin
         state_next.workSave = workRegIn;
         state_next.flagSave = progFlagIn & ~PROTECTED_FLAG_MASK;
      end
      if (restoreInstr) begin
         state_next.workOut = state_reg.workSave;
         state_next.flagOut = (state_reg.flagSave & ~PROTECTED_FLAG_MASK)
                              | (progFlagIn & PROTECTED_FLAG_MASK);
         state_next.restoreV = 1'b1;
      end
      // Entry and return sequencing.
      unique case (state_reg.st)
         ST_RUN: begin
            // Entry waits while asleep; the latched flag then vectors right after wakeup.
            if (instrBoundary && state_reg.globalEnable && pendingIrq && !powerDown) begin
               state_next.take = 1'b1;
               state_next.globalEnable = 1'b0;
               state_next.stackLevel = state_reg.stackLevel - 3'h1;
               state_next.st = ST_ENTER;
            end
         end
         ST_ENTER: state_next.st = ST_SERVICE;
         ST_SERVICE: begin
            if (retInstr) begin
               state_next.globalEnable = 1'b1;
               state_next.stackLevel = state_reg.stackLevel + 3'h1;
               state_next.st = ST_RUN;
            end
         end
         default: state_next.st = ST_RUN;
      endcase
      // Registered copy of the service state, so that output comes from a flip-flop.
      state_next.busy = (state_next.st != ST_RUN);
   end

   // All state registered on every edge; synchronous reset.
   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= '{st: ST_RUN, flags: FLAGS_RESET, enables: ENABLE_RESET,
                        globalEnable: 1'b0, stackLevel: STACK_LEVEL_RESET,
                        edgeField: EDGE_FIELD_RESET, workSave: 8'h00, flagSave: 8'h00,
                        rdData: 8'h00, ack: 1'b0, take: 1'b0, wake: 1'b0,
                        workOut: 8'h00, flagOut: 8'h00, restoreV: 1'b0, busy: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs come straight from flip-flops.
   // The vector address is a fixed constant, as every source shares one entry point.
   assign wb_dat_o = state_reg.rdData;
   assign wb_ack_o = state_reg.ack;
   assign takeVector = state_reg.take;
   assign vectorAddr = IRQ_VECTOR;
   assign wakeRequest = state_reg.wake;
   assign workRegOut = state_reg.workOut;
   assign progFlagOut = state_reg.flagOut;
   assign restoreValid = state_reg.restoreV;
   assign inService = state_reg.busy;

   // Entry and return. These watch registered state, so a wrong next-state term
   // shows up one cycle after the edge that caused it.
   a_entry_clears_enable: assert property (@(posedge clk) disable iff (srst)
      takeVector |-> !state_reg.globalEnable) else $error("global enable left set");
   a_return_sets_enable: assert property (@(posedge clk) disable iff (srst)
      (state_reg.st == ST_SERVICE && retInstr) |=> state_reg.globalEnable)
      else $error("return did not set global enable");
   a_take_needs_global: assert property (@(posedge clk) disable iff (srst)
      takeVector |-> $past(state_reg.globalEnable) && $past(instrBoundary))
      else $error("vector taken without global enable");
   a_take_needs_enable: assert property (@(posedge clk) disable iff (srst)
      takeVector |-> $past(pendingIrq)) else $error("vector taken with nothing enabled");
   a_stack_push: assert property (@(posedge clk) disable iff (srst)
      takeVector |-> state_reg.stackLevel == $past(state_reg.stackLevel) - 3'h1)
      else $error("stack not pushed");
   a_return_pops: assert property (@(posedge clk) disable iff (srst)
      (state_reg.st == ST_SERVICE && retInstr)
      |=> state_reg.stackLevel == $past(state_reg.stackLevel) + 3'h1)
      else $error("stack not popped on return");
   a_no_reentry: assert property (@(posedge clk) disable iff (srst)
      inService |=> !takeVector)
      else $error("second entry while in service");
   a_take_single: assert property (@(posedge clk) disable iff (srst)
      takeVector |=> !takeVector)
      else $error("vector pulse held two cycles");

   // Sleep and wakeup. A sleeping core must never be sent to the vector.
   a_no_take_asleep: assert property (@(posedge clk) disable iff (srst)
      takeVector |-> !$past(powerDown))
      else $error("vector taken while asleep");
   a_wake_needs_sleep: assert property (@(posedge clk) disable iff (srst)
      wakeRequest |-> $past(powerDown) && $past(pinTrigger))
      else $error("wake pulse without a sleeping pin edge");

   // Flag and enable registers.
   a_flag_sets: assert property (@(posedge clk) disable iff (srst)
      usbEvent |=> state_reg.flags[USB_BIT]) else $error("usb flag not set");
   a_set_beats_clear: assert property (@(posedge clk) disable iff (srst)
      (generalTimerEvent && busWrite && wb_adr_i == IRQ_REQUEST_FLAGS_ADDR)
      |=> state_reg.flags[GENERAL_TIMER_BIT]) else $error("set lost to clear");
   a_flag_sticky: assert property (@(posedge clk) disable iff (srst)
      !(busWrite && wb_adr_i == IRQ_REQUEST_FLAGS_ADDR)
      |=> (state_reg.flags & $past(state_reg.flags)) == $past(state_reg.flags))
      else $error("flag cleared without a write");
   a_flag_unused_zero: assert property (@(posedge clk) disable iff (srst)
      (state_reg.flags & ~SOURCE_USED_MASK) == 8'h00)
      else $error("unused flag bit set");
   a_enable_unused_zero: assert property (@(posedge clk) disable iff (srst)
      (state_reg.enables & ~SOURCE_USED_MASK) == 8'h00)
      else $error("unused enable bit set");
   a_enable_reset: assert property (@(posedge clk)
      srst |=> state_reg.enables == ENABLE_RESET && !state_reg.globalEnable)
      else $error("enable reset wrong");

   // Context buffer; the two status bits must never pass through it.
   a_save_copies: assert property (@(posedge clk) disable iff (srst)
      saveInstr |=> state_reg.workSave == $past(workRegIn))
      else $error("work register not saved");
   a_save_masks: assert property (@(posedge clk) disable iff (srst)
      saveInstr |=> (state_reg.flagSave & PROTECTED_FLAG_MASK) == 8'h00)
      else $error("status bits saved");
   a_restore_data: assert property (@(posedge clk) disable iff (srst)
      restoreInstr |=> workRegOut == $past(state_reg.workSave))
      else $error("work register not restored");
   a_restore_keeps: assert property (@(posedge clk) disable iff (srst)
      restoreInstr |=> restoreValid && (progFlagOut & PROTECTED_FLAG_MASK)
      == ($past(progFlagIn) & PROTECTED_FLAG_MASK)) else $error("protected bits changed");

   // Bus handshake.
   a_ack_drop: assert property (@(posedge clk) disable iff (srst)
      wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

   c_take: cover property (@(posedge clk) disable iff (srst) takeVector);
   c_return: cover property (@(posedge clk) disable iff (srst)
      state_reg.st == ST_SERVICE && retInstr);
   c_wake: cover property (@(posedge clk) disable iff (srst) wakeRequest);
   c_restore: cover property (@(posedge clk) disable iff (srst) restoreValid);
   c_set_clear: cover property (@(posedge clk) disable iff (srst)
      generalTimerEvent && busWrite && wb_adr_i == IRQ_REQUEST_FLAGS_ADDR);
endmodule

//--- tb/miu_core_model.sv
// Core sequencer model that sits beside the interrupt unit.
// It paces instruction boundaries and returns from service after a fixed time.
// Assumes one clock and the unit's synchronous active-high reset.
`timescale 1ns/1ps
module miu_core_model (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Pace: 0 gives a boundary every cycle, 1 every fourth cycle.
   input wire logic slowMode,
   // From the unit.
   input wire logic inService,
   // To the unit.
   output logic instrBoundary,
   output logic retInstr
);
   logic [1:0] paceCount;
   logic [4:0] svcCount;
   // A slow core stretches instructions, so the unit must wait for a boundary.
   // The return is issued only while in service, once, after a fixed dwell.
   always @(posedge clk) begin
      if (srst) begin
         paceCount <= 2'h0;
         svcCount <= 5'h00;
         instrBoundary <= 1'b0;
         retInstr <= 1'b0;
      end else begin
         paceCount <= paceCount + 2'h1;
         instrBoundary <= !slowMode || (paceCount == 2'h3);
         svcCount <= inService ? svcCount + 5'h01 : 5'h00;
         retInstr <= inService && (svcCount == 5'h18);
      end
   end
endmodule

//--- tb/miu_interrupt_unit_tb.sv
// Self-checking bench for the interrupt unit, with the core model beside it.
// Assumes the unit acknowledges each Wishbone request one cycle after taking it.
`timescale 1ns/1ps
module miu_interrupt_unit_tb
   import miu_pkg::*;
;
   logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, sel = 1'b0;
   logic pin = 1'b1, powerDown = 1'b0, slowMode = 1'b0, saveI = 1'b0, restoreI = 1'b0;
   logic [7:0] adr = 8'h00, dat = 8'h00, workIn = 8'h00, flagIn = 8'h00;
   logic [4:0] ev = 5'h00;
   logic [7:0] datO, workOut, flagOut;
   logic ack, wake, take, restoreValid, inService, boundary, ret;
   logic [15:0] vec;
   int mismatches = 0, n_compared = 0, nTake = 0, nWake = 0;
   int pos[5] = '{CAPTURE_ONE_BIT, CAPTURE_TWO_BIT, GENERAL_TIMER_BIT, TIMER_COUNTER_BIT, USB_BIT};
   // Free-running 100 MHz clock.
   always #5 clk = ~clk;
   miu_interrupt_unit i_dut (
      .clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(datO), .wb_ack_o(ack),
      .generalTimerEvent(ev[2]), .timerCounterEvent(ev[3]), .usbEvent(ev[4]),
      .captureOneEvent(ev[0]), .captureTwoEvent(ev[1]), .externalPinInterrupt(pin),
      .powerDown(powerDown), .wakeRequest(wake), .instrBoundary(boundary), .retInstr(ret),
      .saveInstr(saveI), .restoreInstr(restoreI), .workRegIn(workIn), .progFlagIn(flagIn),
      .takeVector(take), .vectorAddr(vec), .workRegOut(workOut), .progFlagOut(flagOut),
      .restoreValid(restoreValid), .inService(inService));
   miu_core_model i_core (.clk(clk), .srst(srst), .slowMode(slowMode),
      .inService(inService), .instrBoundary(boundary), .retInstr(ret));
   // Count vector entries and wake pulses; each lasts exactly one cycle.
   always @(posedge clk) begin
      if (take === 1'b1) nTake++;
      if (wake === 1'b1) nWake++;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One classic cycle; the request stands until ack is sampled high.
   // A missing ack is left to the watchdog; the answer is due on the second edge.
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1);
      q = datO;
      chk(16'(n), 16'h0002);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      wb(1'b0, a, 8'h00, q);
      chk(16'(q), 16'(e));
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic pulse(input logic [4:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 5'h00;
   endtask
   // Waiting is bounded; exactly one entry is expected and it jumps to the vector.
   task automatic waitTake(input int k);
      int n;
      n = 0;
      while (nTake == k && n < 60) begin
         @(posedge clk);
         n++;
      end
      chk(16'(nTake), 16'(k + 1));
      chk(vec, 16'h0008);
   endtask
   task automatic waitRet();
      int n;
      n = 0;
      while (inService !== 1'b0 && n < 100) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic t_reset();
      rd(IRQ_REQUEST_FLAGS_ADDR, 8'h00);
      rd(IRQ_ENABLE_MASK_ADDR, 8'h00);
      rd(STACK_POINTER_ADDR, 8'h07);
      rd(PIN_EDGE_SELECT_ADDR, 8'h10);
      rd(8'h00, 8'h00);
      wr(IRQ_ENABLE_MASK_ADDR, 8'hff);
      rd(IRQ_ENABLE_MASK_ADDR, 8'h77);
      wr(IRQ_REQUEST_FLAGS_ADDR, 8'hff);
      rd(IRQ_REQUEST_FLAGS_ADDR, 8'h77);
      // A timer event in the cycle of a clearing write keeps its own flag.
      fork
         wr(IRQ_REQUEST_FLAGS_ADDR, 8'h00);
         pulse(5'h04);
      join
      rd(IRQ_REQUEST_FLAGS_ADDR, 8'h10);
      wr(IRQ_REQUEST_FLAGS_ADDR, 8'h00);
      wr(IRQ_ENABLE_MASK_ADDR, 8'h00);
   endtask
   // Each internal source: flag rises with its enable off, entry follows the enable.
   task automatic t_sources();
      int k;
      wr(STACK_POINTER_ADDR, 8'h87);
      for (int i = 0; i < 5; i++) begin
         k = nTake;
         pulse(5'(1 << i));
         rd(IRQ_REQUEST_FLAGS_ADDR, 8'(1 << pos[i]));
         chk(16'(nTake), 16'(k));
         wr(IRQ_ENABLE_MASK_ADDR, 8'(1 << pos[i]));
         waitTake(k);
         rd(STACK_POINTER_ADDR, 8'h06);
         wr(IRQ_REQUEST_FLAGS_ADDR, 8'h00);
         waitRet();
         rd(STACK_POINTER_ADDR, 8'h87);
         wr(IRQ_ENABLE_MASK_ADDR, 8'h00);
      end
   endtask
   task automatic t_global();
      int k;
      slowMode <= 1'b1;
      wr(STACK_POINTER_ADDR, 8'h07);
      wr(IRQ_ENABLE_MASK_ADDR, 8'h40);
      k = nTake;
      pulse(5'h10);
      repeat (10) @(posedge clk);
      chk(16'(nTake), 16'(k));
      wr(STACK_POINTER_ADDR, 8'h87);
      waitTake(k);
      wr(IRQ_REQUEST_FLAGS_ADDR, 8'h00);
      waitRet();
      wr(IRQ_ENABLE_MASK_ADDR, 8'h00);
      slowMode <= 1'b0;
   endtask
   task automatic edgeStep(input logic lvl, input logic [7:0] e);
      @(posedge clk);
      pin <= lvl;
      repeat (3) @(posedge clk);
      rd(IRQ_REQUEST_FLAGS_ADDR, e);
      wr(IRQ_REQUEST_FLAGS_ADDR, 8'h00);
   endtask
   // A falling pin edge in power-down wakes the chip; entry waits until power-down ends.
   task automatic t_pin();
      int k, w;
      wr(IRQ_ENABLE_MASK_ADDR, 8'h01);
      powerDown <= 1'b1;
      k = nTake;
      w = nWake;
      @(posedge clk);
      pin <= 1'b0;
      repeat (4) @(posedge clk);
      chk(16'(nWake), 16'(w + 1));
      rd(IRQ_REQUEST_FLAGS_ADDR, 8'h01);
      chk(16'(nTake), 16'(k));
      powerDown <= 1'b0;
      waitTake(k);
      wr(IRQ_REQUEST_FLAGS_ADDR, 8'h00);
      waitRet();
      wr(IRQ_ENABLE_MASK_ADDR, 8'h00);
      wr(PIN_EDGE_SELECT_ADDR, 8'h08);
      edgeStep(1'b1, 8'h01);
      edgeStep(1'b0, 8'h00);
      wr(PIN_EDGE_SELECT_ADDR, 8'h18);
      edgeStep(1'b1, 8'h01);
      edgeStep(1'b0, 8'h01);
      wr(PIN_EDGE_SELECT_ADDR, 8'h10);
      edgeStep(1'b1, 8'h00);
      edgeStep(1'b0, 8'h01);
      // The reserved code must ignore both edges; awake, no edge may request a wake.
      wr(PIN_EDGE_SELECT_ADDR, 8'h00);
      rd(PIN_EDGE_SELECT_ADDR, 8'h00);
      edgeStep(1'b1, 8'h00);
      edgeStep(1'b0, 8'h00);
      chk(16'(nWake), 16'(w + 1));
   endtask
   // Save then restore; the two status bits keep the live value on restore.
   task automatic t_save();
      @(posedge clk);
      workIn <= 8'ha5;
      flagIn <= 8'h7f;
      saveI <= 1'b1;
      @(posedge clk);
      saveI <= 1'b0;
      flagIn <= 8'h80;
      rd(WORK_SAVE_ADDR, 8'ha5);
      rd(FLAG_SAVE_ADDR, 8'h3f);
      @(posedge clk);
      restoreI <= 1'b1;
      @(posedge clk);
      restoreI <= 1'b0;
      @(posedge clk);
      chk(16'(restoreValid), 16'h0001);
      chk(16'(workOut), 16'h00a5);
      chk(16'(flagOut), 16'h00bf);
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Main sequence: reset for ten cycles, then every scenario in turn.
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_sources();
      t_global();
      t_pin();
      t_save();
      conclude();
   end
   // The run needs a few hundred cycles; this limit only cuts a hang short.
   initial begin
      #300us;
      mismatches++;
      conclude();
   end
endmodule
